/* rtl/osc_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - new source codes: low_power_rc_osc, sosc, posc, pll, frc
// - new source loads from straps one cycle after reset release
// - lock bit refuses source and pll changes
// - wait enters sleep or idle per bit
// - fail flag sets on monitor failure
// - usb clock from fast rc when set
// - secondary oscillator runs while enabled
// - switch request clears when switch completes
// - switch request reset follows two-speed strap
// - oscillator and pll control writes need unlock sequence first; reference control writes do not
// - pll divider codes map 1..12
// - fast rc pll input forces divide-by-one
// - pll source bit picks fast rc or primary
// - pll writes blocked while running from pll
// - run-in-sleep ignored for sources zero, one
module osc_ctrl (
	input  wire logic                 clk_sys,        // 20 MHz system clock
	input  wire logic                 sys_rst,        // sync reset, active high
	input  wire logic                 clk_en,         // freeze all state when low
	input  wire osc_pkg::osc_cfg_s    cfg,            // configuration straps
	input  wire osc_pkg::osc_apb_req_s apb_req,       // apb request group
	output logic                      pready,         // apb ready
	output logic [31:0]               prdata,         // apb read data
	output logic                      pslverr,        // apb error
	input  wire logic                 fail_detect,    // monitor failure pin
	input  wire logic                 wait_exec,      // wait instruction pulse
	input  wire logic                 ref_src_tick,   // selected reference source edge
	input  wire logic                 sleep_active,   // device asleep
	output osc_pkg::osc_ctl_s         ctl,            // clock steering
	output logic                      enter_sleep,    // wait goes to sleep
	output logic                      enter_idle,     // wait goes to idle
	output logic                      ref_clk_out,    // reference clock pin
	output logic                      ref_clk_oe      // reference pin enable
);
	import osc_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic [2:0]  new_osc_select;
	logic [2:0]  current_osc_select;
	logic        clock_select_lock;
	logic        sleep_on_wait_enable;
	logic        clock_fail_flag;
	logic        usb_fast_rc_enable;
	logic        secondary_osc_enable;
	logic        osc_switch_request;
	logic [2:0]  pll_input_divider;
	logic        pll_input_source;
	logic [14:0] ref_clock_divider;
	logic        ref_on;
	logic        stop_in_idle;
	logic        ref_out_enable;
	logic        ref_run_in_sleep;
	logic        ref_divider_switch_enable;
	logic        ref_active;
	logic [3:0]  ref_source_select;
	logic [1:0]  unlock_step;
	logic [7:0]  settle_cnt;
	osc_state_e  state;
	osc_state_e  next_state;
	logic [2:0]  fail_sync;
	logic        seeded;
	logic        ref_raw;

	// ****************************************
	// bus decode
	// ****************************************
	wire access    = apb_req.psel && apb_req.penable;
	wire wr        = access && apb_req.pwrite;
	wire hit_osc   = apb_req.paddr == OSC_ADDR_OSC_CTRL;
	wire hit_pll   = apb_req.paddr == OSC_ADDR_PLL_CTRL;
	wire hit_ref   = apb_req.paddr == OSC_ADDR_REF_CTRL;
	wire hit_unl   = apb_req.paddr == OSC_ADDR_UNLOCK;
	wire hit_stat  = apb_req.paddr == OSC_ADDR_STATUS;
	wire mapped    = hit_osc || hit_pll || hit_ref || hit_unl || hit_stat;
	wire unlocked  = unlock_step == 2'h2;
	wire wr_osc    = wr && hit_osc && unlocked;
	wire wr_pll    = wr && hit_pll && unlocked && !clock_select_lock
		&& current_osc_select != OSC_SRC_SYSTEM_PLL;
	wire wr_ref    = wr && hit_ref;
	wire [31:0] wd = apb_req.pwdata;

	// single-cycle access phase, no wait states
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// ****************************************
	// readback mux
	// ****************************************
	wire [31:0] rd_osc = {17'h0, current_osc_select, 1'b0, new_osc_select, clock_select_lock, 2'h0,
		sleep_on_wait_enable, clock_fail_flag, usb_fast_rc_enable, secondary_osc_enable, osc_switch_request};
	wire [31:0] rd_pll = {21'h0, pll_input_divider, pll_input_source, 7'h0};
	wire [31:0] rd_ref = {1'b0, ref_clock_divider, ref_on, 1'b0, stop_in_idle, ref_out_enable,
		ref_run_in_sleep, 1'b0, ref_divider_switch_enable, ref_active, 4'h0, ref_source_select};
	wire [31:0] rd_stat = {30'h0, unlocked, 1'b0};
	wire [31:0] rd_mux = hit_osc ? rd_osc : hit_pll ? rd_pll : hit_ref ? rd_ref : hit_stat ? rd_stat : 32'h0;

	// read data registered at the setup cycle so it stands through access
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= 32'h0;
		end else if (clk_en && apb_req.psel && !apb_req.penable) begin
			prdata <= rd_mux;
		end
	end

	// ****************************************
	// unlock sequence: two keys, then one write
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			unlock_step <= 2'h0;
		end else if (clk_en && wr) begin
			if (hit_unl && wd == OSC_KEY1)
				unlock_step <= 2'h1;
			else if (hit_unl && wd == OSC_KEY2 && unlock_step == 2'h1)
				unlock_step <= 2'h2;
			else
				unlock_step <= 2'h0;
		end
	end

	// ****************************************
	// fail pin synchroniser: change on stages two and three agreeing
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fail_sync <= 3'h0;
		end else if (clk_en) begin
			fail_sync <= {fail_sync[1:0], fail_detect};
		end
	end
	wire fail_seen = fail_sync[1] && fail_sync[2];

	// ****************************************
	// switch sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			OSC_ST_IDLE:   if (osc_switch_request && seeded) next_state = OSC_ST_SETTLE;
			OSC_ST_SETTLE: if (settle_cnt == 8'h0) next_state = OSC_ST_DONE;
			OSC_ST_DONE:   next_state = OSC_ST_IDLE;
			default:       next_state = OSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state      <= OSC_ST_IDLE;
			settle_cnt <= 8'h0;
		end else if (clk_en) begin
			state      <= next_state;
			settle_cnt <= (state == OSC_ST_IDLE) ? OSC_SWITCH_CNT - 8'h1 : settle_cnt - 8'h1;
		end
	end

	// ****************************************
	// oscillator control register
	// ****************************************
	// straps are caught one cycle after reset release, not under reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			seeded               <= 1'b0;
			new_osc_select       <= OSC_SRC_FRC_DIV;
			current_osc_select   <= OSC_SRC_FRC_DIV;
			clock_select_lock    <= 1'b0;
			sleep_on_wait_enable <= 1'b0;
			clock_fail_flag      <= 1'b0;
			usb_fast_rc_enable   <= 1'b0;
			secondary_osc_enable <= 1'b0;
			osc_switch_request   <= 1'b0;
			pll_input_divider    <= 3'h0;
			pll_input_source     <= 1'b0;
		end else if (clk_en) begin
			seeded <= 1'b1;
			if (!seeded) begin
				new_osc_select     <= cfg.initial_osc_select;
				current_osc_select <= cfg.initial_osc_select;
				osc_switch_request <= cfg.two_speed_startup;
				pll_input_divider  <= cfg.pll_input_divider;
				pll_input_source   <= cfg.pll_input_source;
			end else begin
				if (wr_osc) begin
					if (!clock_select_lock)
						new_osc_select <= wd[OSC_POS_NEW_SEL +: 3];
					clock_select_lock    <= wd[OSC_POS_LOCK] | clock_select_lock;
					sleep_on_wait_enable <= wd[OSC_POS_SLEEP];
					usb_fast_rc_enable   <= wd[OSC_POS_USB_FRC];
					secondary_osc_enable <= wd[OSC_POS_SOSC_EN];
				end
				// completion wins over a fresh write only once settle ends
				if (state == OSC_ST_DONE) begin
					current_osc_select <= new_osc_select;
					osc_switch_request <= 1'b0;
				end else if (wr_osc && wd[OSC_POS_SWITCH] && !clock_select_lock) begin
					osc_switch_request <= 1'b1;
				end
				if (wr_pll) begin
					pll_input_divider <= wd[OSC_POS_PLL_DIV +: 3];
					pll_input_source  <= wd[OSC_POS_PLL_SRC];
				end
			end
			// failure set wins over a software clear
			if (fail_seen)
				clock_fail_flag <= 1'b1;
			else if (wr_osc && !wd[OSC_POS_FAIL])
				clock_fail_flag <= 1'b0;
		end
	end

	// ****************************************
	// reference clock control register
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ref_clock_divider         <= 15'h0;
			ref_on                    <= 1'b0;
			stop_in_idle              <= 1'b0;
			ref_out_enable            <= 1'b0;
			ref_run_in_sleep          <= 1'b0;
			ref_divider_switch_enable <= 1'b0;
			ref_active                <= 1'b0;
			ref_source_select         <= 4'h0;
		end else if (clk_en) begin
			if (wr_ref) begin
				ref_clock_divider <= wd[OSC_POS_REF_DIV +: 15];
				ref_on            <= wd[OSC_POS_REF_ON];
				stop_in_idle      <= wd[OSC_POS_REF_STOP_IN_IDLE];
				ref_out_enable    <= wd[OSC_POS_REF_OE];
				ref_run_in_sleep  <= wd[OSC_POS_REF_SLP];
				ref_source_select <= wd[OSC_POS_REF_SEL +: 4];
			end
			// divider switch completes one cycle after it is seen
			if (wr_ref && wd[OSC_POS_REF_DSW])
				ref_divider_switch_enable <= 1'b1;
			else if (ref_divider_switch_enable)
				ref_divider_switch_enable <= 1'b0;
			ref_active <= ref_on;
		end
	end

	// ****************************************
	// reference output
	// ****************************************
	// sources zero and one follow the system clock, which stops in sleep anyway
	wire ref_sleep_ok = ref_run_in_sleep && ref_source_select != OSC_REF_SEL_SYS
		&& ref_source_select != OSC_REF_SEL_PB;
	wire ref_run = ref_active && (!sleep_active || ref_sleep_ok);

	osc_ref_div u_ref_div (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.run      (ref_run),
		.src_tick (ref_src_tick),
		.divisor  (ref_clock_divider),
		.ref_out  (ref_raw)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ref_clk_out <= 1'b0;
			ref_clk_oe  <= 1'b0;
		end else if (clk_en) begin
			ref_clk_out <= ref_raw && ref_out_enable;
			ref_clk_oe  <= ref_out_enable && ref_active;
		end
	end

	// ****************************************
	// wait handling and steering
	// ****************************************
	assign enter_sleep = wait_exec && sleep_on_wait_enable;
	assign enter_idle  = wait_exec && !sleep_on_wait_enable;

	// divide code table: 1,2,3,4,5,6,10,12
	wire [3:0] div_table = (pll_input_divider == 3'h7) ? 4'hc :
		(pll_input_divider == 3'h6) ? 4'ha : 4'(pll_input_divider) + 4'h1;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctl <= '0;
		end else if (clk_en) begin
			ctl.current_osc_select   <= current_osc_select;
			ctl.secondary_osc_enable <= secondary_osc_enable;
			ctl.usb_fast_rc_enable   <= usb_fast_rc_enable;
			ctl.pll_input_source     <= pll_input_source;
			ctl.pll_divide_by        <= pll_input_source ? 4'h1 : div_table;
			ctl.sleep_on_wait        <= sleep_on_wait_enable;
			ctl.idle_on_wait         <= !sleep_on_wait_enable;
		end
	end
endmodule

/* rtl/osc_pkg.sv */
package osc_pkg;

	// ****************************************
	// register map (byte addresses, chosen)
	// ****************************************
	localparam logic [7:0] OSC_ADDR_OSC_CTRL  = 8'h00;
	localparam logic [7:0] OSC_ADDR_PLL_CTRL  = 8'h10;
	localparam logic [7:0] OSC_ADDR_REF_CTRL  = 8'h20;
	localparam logic [7:0] OSC_ADDR_UNLOCK    = 8'h30;
	localparam logic [7:0] OSC_ADDR_STATUS    = 8'h34;

	// unlock keys, written in sequence to the unlock register
	localparam logic [31:0] OSC_KEY1 = 32'haa99_6655;
	localparam logic [31:0] OSC_KEY2 = 32'h5566_99aa;

	// ****************************************
	// oscillator control fields
	// ****************************************
	localparam int OSC_POS_NEW_SEL  = 8;
	localparam int OSC_POS_CUR_SEL  = 12;
	localparam int OSC_POS_LOCK     = 7;
	localparam int OSC_POS_SLEEP    = 4;
	localparam int OSC_POS_FAIL     = 3;
	localparam int OSC_POS_USB_FRC  = 2;
	localparam int OSC_POS_SOSC_EN  = 1;
	localparam int OSC_POS_SWITCH   = 0;

	// pll control fields
	localparam int OSC_POS_PLL_DIV  = 8;
	localparam int OSC_POS_PLL_SRC  = 7;

	// reference clock control fields
	localparam int OSC_POS_REF_DIV  = 16;
	localparam int OSC_POS_REF_ON   = 15;
	localparam int OSC_POS_REF_STOP_IN_IDLE = 13;
	localparam int OSC_POS_REF_OE   = 12;
	localparam int OSC_POS_REF_SLP  = 11;
	localparam int OSC_POS_REF_DSW  = 9;
	localparam int OSC_POS_REF_ACT  = 8;
	localparam int OSC_POS_REF_SEL  = 0;

	// oscillator source codes
	localparam logic [2:0] OSC_SRC_FRC_DIV = 3'h0;
	localparam logic [2:0] OSC_SRC_SYSTEM_PLL    = 3'h1;
	localparam logic [2:0] OSC_SRC_PRIMARY = 3'h2;
	localparam logic [2:0] OSC_SRC_SECOND  = 3'h4;
	localparam logic [2:0] OSC_SRC_LOW_POWER_RC_OSC    = 3'h5;

	// reference sources that ignore run-in-sleep
	localparam logic [3:0] OSC_REF_SEL_SYS = 4'h0;
	localparam logic [3:0] OSC_REF_SEL_PB  = 4'h1;

	// switch settle time and its cycle count at 20 MHz
	localparam int OSC_CLK_HZ       = 20_000_000;
	localparam int OSC_SWITCH_NS    = 400;
	localparam int OSC_SWITCH_CYC   = (OSC_SWITCH_NS * (OSC_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0] OSC_SWITCH_CNT = 8'(OSC_SWITCH_CYC);

	// switch state machine
	typedef enum logic [2:0] {
		OSC_ST_IDLE   = 3'b001,
		OSC_ST_SETTLE = 3'b010,
		OSC_ST_DONE   = 3'b100
	} osc_state_e;

	// configuration straps
	typedef struct packed {
		logic [2:0] initial_osc_select;
		logic       two_speed_startup;
		logic [2:0] pll_input_divider;
		logic       pll_input_source;
	} osc_cfg_s;

	// apb request
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} osc_apb_req_s;

	// clock steering outputs
	typedef struct packed {
		logic [2:0] current_osc_select;
		logic       secondary_osc_enable;
		logic       usb_fast_rc_enable;
		logic       pll_input_source;
		logic [3:0] pll_divide_by;
		logic       sleep_on_wait;
		logic       idle_on_wait;
	} osc_ctl_s;

endpackage

/* rtl/osc_ref_div.sv */
`timescale 1ns/1ps
module osc_ref_div (
	input  wire logic        clk_sys,     // system clock
	input  wire logic        sys_rst,     // sync reset
	input  wire logic        clk_en,      // freeze when low
	input  wire logic        run,         // divider running
	input  wire logic        src_tick,    // selected source edge
	input  wire logic [14:0] divisor,     // half-period count
	output logic             ref_out      // divided clock
);
	import osc_pkg::*;

	logic [14:0] count;
	logic        toggle;

	// zero divisor passes each source tick straight through
	assign toggle = src_tick && (divisor == 15'h0 || count == divisor - 15'h1);

	// ****************************************
	// divider counter
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count   <= 15'h0;
			ref_out <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				count   <= 15'h0;
				ref_out <= 1'b0;
			end else if (toggle) begin
				count   <= 15'h0;
				ref_out <= !ref_out;
			end else if (src_tick) begin
				count <= count + 15'h1;
			end
		end
	end
endmodule

/* tb/osc_ctrl_props.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module osc_ctrl_props (
	input wire logic                  clk_sys,      // clock
	input wire logic                  sys_rst,      // reset
	input wire logic                  clk_en,       // run
	input wire osc_pkg::osc_cfg_s     cfg,          // straps
	input wire osc_pkg::osc_apb_req_s apb_req,      // bus
	input wire logic                  pready,       // ready
	input wire logic [31:0]           prdata,       // rdata
	input wire logic                  pslverr,      // error
	input wire logic                  fail_detect,  // fail pin
	input wire logic                  wait_exec,    // wait
	input wire logic                  ref_src_tick, // tick
	input wire logic                  sleep_active, // asleep
	input wire osc_pkg::osc_ctl_s     ctl,          // steering
	input wire logic                  enter_sleep,  // sleep
	input wire logic                  enter_idle,   // idle
	input wire logic                  ref_clk_out,  // ref out
	input wire logic                  ref_clk_oe    // ref oe
);
	import osc_pkg::*;
	// ctl holds straps only from the second edge after release
	logic [1:0] rst_age;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) rst_age <= 2'h0;
		else if (rst_age != 2'h3) rst_age <= rst_age + 2'h1;
	end
	wire settled = (rst_age == 2'h3);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_wait_one_mode: assert property (wait_exec |-> (enter_sleep ^ enter_idle))
		else $error("wait gave no single mode");
	a_wait_has_cause: assert property ((enter_sleep || enter_idle) |-> wait_exec)
		else $error("mode entry without wait");
	a_sel_code_legal: assert property (settled |-> ctl.current_osc_select inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
		else $error("reserved source selected");
	a_frc_div_one: assert property (settled && ctl.pll_input_source |-> ctl.pll_divide_by == 4'h1)
		else $error("fast rc input not divide by one");
	a_pll_div_legal: assert property (settled |-> ctl.pll_divide_by inside {1, 2, 3, 4, 5, 6, 10, 12})
		else $error("illegal pll divide");
	a_pll_frozen: assert property (settled && ctl.current_osc_select == 3'h1 && $past(ctl.current_osc_select, 2) == 3'h1
		|-> $stable(ctl.pll_divide_by) && $stable(ctl.pll_input_source)) else $error("pll changed while in use");
	a_reset_sel: assert property ($fell(sys_rst) |-> ##2 ctl.current_osc_select == cfg.initial_osc_select)
		else $error("select not from straps");
	a_reset_pll: assert property ($fell(sys_rst) |-> ##2 ctl.pll_input_source == cfg.pll_input_source)
		else $error("pll source not from straps");
	c_sleep: cover property (enter_sleep);
	c_on_pll: cover property (ctl.current_osc_select == 3'h1);
	c_bus_err: cover property (pslverr);
endmodule
bind osc_ctrl osc_ctrl_props u_props (.clk_sys, .sys_rst, .clk_en, .cfg, .apb_req, .pready, .prdata, .pslverr,
	.fail_detect, .wait_exec, .ref_src_tick, .sleep_active, .ctl, .enter_sleep, .enter_idle, .ref_clk_out, .ref_clk_oe);

/* tb/osc_ctrl_tb.sv */
`timescale 1ns/1ps
module osc_ctrl_tb;
	import osc_pkg::*;
	// ****
	// stimulus and wiring
	// ****
	logic         clk_sys = 1'b0;
	logic         sys_rst = 1'b1;
	logic         clk_en = 1'b1;         // freeze path left untested
	osc_cfg_s     cfg = 8'h5a;           // primary, two-speed, divide 6, posc
	osc_apb_req_s apb_req = '0;
	logic         wait_exec = 1'b0;
	logic         fail_detect = 1'b0;
	logic         ref_src_tick = 1'b0;
	logic         sleep_active = 1'b0;
	logic         tick_on = 1'b0;
	logic         pready, pslverr, enter_sleep, enter_idle, ref_clk_out, ref_clk_oe, err;
	logic [31:0]  prdata, rd;
	osc_ctl_s     ctl;
	logic [3:0]   divs [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};
	int           mismatches = 0;
	int           num_checks = 0;
	int           cycles = 0;
	always #25 clk_sys = ~clk_sys;
	// source ticks every other cycle, so level and edge readings agree
	always @(posedge clk_sys) ref_src_tick <= tick_on & ~ref_src_tick;
	osc_ctrl u_dut (.clk_sys, .sys_rst, .clk_en, .cfg, .apb_req, .pready, .prdata, .pslverr, .fail_detect,
		.wait_exec, .ref_src_tick, .sleep_active, .ctl, .enter_sleep, .enter_idle, .ref_clk_out, .ref_clk_oe);
	// ****
	// shared tasks
	// ****
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error %0t: %s", $time, m);
		end
	endtask
	// one apb transfer; an edge passes first so requests never collide
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task unlock_wr(input logic [7:0] a, input logic [31:0] d);
		apb(OSC_ADDR_UNLOCK, 1'b1, OSC_KEY1);
		apb(OSC_ADDR_UNLOCK, 1'b1, OSC_KEY2);
		apb(a, 1'b1, d);
	endtask
	task pulse_wait(input logic slp);
		@(posedge clk_sys);
		wait_exec <= 1'b1;
		#1 chk(enter_sleep === slp && enter_idle === !slp, "wait mode");
		chk(ctl.sleep_on_wait === slp && ctl.idle_on_wait === !slp, "wait steering");
		@(posedge clk_sys);
		wait_exec <= 1'b0;
	endtask
	// cycles between two output edges, phase independent
	task period(output int c);
		logic last;
		last = ref_clk_out;
		while (ref_clk_out === last) @(posedge clk_sys);
		last = ref_clk_out;
		c = 0;
		while (ref_clk_out === last) begin @(posedge clk_sys); c++; end
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		apb(OSC_ADDR_OSC_CTRL, 1'b0, 32'h0);
		chk(rd[10:8] === OSC_SRC_PRIMARY, "strap select");
		chk(rd[0] === 1'b1, "switch request reset");
		chk(rd[3] === 1'b0, "fail flag idle");
		repeat (20) @(posedge clk_sys);
		apb(OSC_ADDR_OSC_CTRL, 1'b0, 32'h0);
		chk(rd[0] === 1'b0, "switch request stuck");
		chk(ctl.pll_divide_by === 4'h6, "strap divider");
		apb(8'h3c, 1'b0, 32'h0);
		chk(err === 1'b1, "unmapped access");
	endtask
	task t_switch;
		apb(OSC_ADDR_OSC_CTRL, 1'b1, 32'h0000_0417);
		repeat (20) @(posedge clk_sys);
		chk(ctl.current_osc_select === OSC_SRC_PRIMARY && ctl.secondary_osc_enable === 1'b0, "locked write");
		unlock_wr(OSC_ADDR_OSC_CTRL, 32'h0000_0417);
		repeat (20) @(posedge clk_sys);
		chk(ctl.current_osc_select === OSC_SRC_SECOND, "switch");
		chk(ctl.secondary_osc_enable === 1'b1, "sosc on");
		chk(ctl.usb_fast_rc_enable === 1'b1, "usb frc");
		pulse_wait(1'b1);
		unlock_wr(OSC_ADDR_OSC_CTRL, 32'h0000_0400);
		repeat (3) @(posedge clk_sys);
		pulse_wait(1'b0);
		chk(ctl.secondary_osc_enable === 1'b0 && ctl.usb_fast_rc_enable === 1'b0, "sosc/usb off");
	endtask
	task t_pll;
		for (int i = 0; i < 8; i++) begin
			unlock_wr(OSC_ADDR_PLL_CTRL, 32'(i) << 8);
			repeat (2) @(posedge clk_sys);
			chk(ctl.pll_divide_by === divs[i], "pll divider code");
		end
		unlock_wr(OSC_ADDR_PLL_CTRL, 32'h0000_0780);
		repeat (2) @(posedge clk_sys);
		chk(ctl.pll_input_source === 1'b1 && ctl.pll_divide_by === 4'h1, "frc input");
		apb(OSC_ADDR_PLL_CTRL, 1'b1, 32'h0000_0300);
		repeat (2) @(posedge clk_sys);
		chk(ctl.pll_input_source === 1'b1, "pll locked write");
	endtask
	task t_lock;
		unlock_wr(OSC_ADDR_PLL_CTRL, 32'h0000_0300);
		unlock_wr(OSC_ADDR_OSC_CTRL, 32'h0000_0101);
		repeat (20) @(posedge clk_sys);
		chk(ctl.current_osc_select === OSC_SRC_SYSTEM_PLL, "to pll");
		unlock_wr(OSC_ADDR_PLL_CTRL, 32'h0000_0100);
		repeat (2) @(posedge clk_sys);
		chk(ctl.pll_divide_by === 4'h4, "pll write in use");
		unlock_wr(OSC_ADDR_OSC_CTRL, 32'h0000_0180);
		unlock_wr(OSC_ADDR_OSC_CTRL, 32'h0000_0201);
		repeat (20) @(posedge clk_sys);
		apb(OSC_ADDR_OSC_CTRL, 1'b0, 32'h0);
		chk(rd[10:8] === OSC_SRC_SYSTEM_PLL && rd[7] === 1'b1, "lock select");
		chk(ctl.current_osc_select === OSC_SRC_SYSTEM_PLL, "lock switch");
		fail_detect <= 1'b1;
		repeat (6) @(posedge clk_sys);
		apb(OSC_ADDR_OSC_CTRL, 1'b0, 32'h0);
		chk(rd[3] === 1'b1, "fail flag");
		fail_detect <= 1'b0;
	endtask
	task t_ref;
		int c;
		tick_on <= 1'b1;
		apb(OSC_ADDR_REF_CTRL, 1'b1, 32'h0000_9002);
		repeat (3) @(posedge clk_sys);
		apb(OSC_ADDR_REF_CTRL, 1'b0, 32'h0);
		chk(rd[8] === 1'b1, "request status on");
		chk(ref_clk_oe === 1'b1, "reference pin enable");
		period(c);
		chk(c == 2, "undivided period");
		apb(OSC_ADDR_REF_CTRL, 1'b1, 32'h0003_9202);
		repeat (3) @(posedge clk_sys);
		apb(OSC_ADDR_REF_CTRL, 1'b0, 32'h0);
		chk(rd[9] === 1'b0, "divider switch clear");
		period(c);
		chk(c == 6, "divided period");
		sleep_active <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(ref_clk_out === 1'b0, "stops in sleep without run-in-sleep");
		sleep_active <= 1'b0;
		apb(OSC_ADDR_REF_CTRL, 1'b1, 32'h0000_1002);
		repeat (3) @(posedge clk_sys);
		apb(OSC_ADDR_REF_CTRL, 1'b0, 32'h0);
		chk(rd[8] === 1'b0, "request status off");
	endtask
	// hang guard, well above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			summarize;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset;
		t_switch;
		t_pll;
		t_lock;
		t_ref;
		summarize;
	end
endmodule
